// File: rtl/event_status_capture.sv
module event_status_capture
  import event_status_pkg::*;
#(
  parameter int SILENCE_CYC = SILENCE_CYCLES
) (
  input wire logic sys_clk_in, // 200 MHz system clock
  input wire logic reset_n_in, // async reset, active low
  input wire reg_req_t reg_req_in, // register access request
  output logic [7:0] reg_rdata_out, // read data, one cycle after rd
  input wire sys_evt_t sys_evt_in, // system event sources
  input wire sup_evt_t sup_evt_in, // supply event sources
  input wire trx_evt_t trx_evt_in, // transceiver event sources
  input wire cap_en_t cap_en_in, // capture enables
  input wire logic sleep_in, // device in sleep state
  input wire logic wd_window_in, // watchdog in window operation
  input wire logic wd_timeout_in, // watchdog in timeout operation
  input wire logic spi_frame_end_in, // serial frame ended, pulse
  input wire logic [5:0] spi_bit_count_in, // clocks in that frame
  input wire logic trx_offline_in, // transceiver offline
  input wire logic main_reg_on_in, // main regulator active
  input wire logic wake_pin_pending_in, // any wake pin flag set
  input wire logic trx_other_pending_in, // other transceiver flags set
  output logic rxd_force_low_out, // drive receive pin low
  output logic sys_reset_req_out, // system reset request pulse
  output logic [7:0] summary_out // global summary copy
);

  localparam logic [SIL_CNT_W-1:0] SIL_LAST = SIL_CNT_W'(SILENCE_CYC - 1);

  logic [7:0] sys_flags;
  logic [7:0] sup_flags;
  logic [7:0] trx_flags;
  logic [7:0] sys_set;
  logic [7:0] sup_set;
  logic [7:0] trx_set;
  logic [7:0] sys_clr;
  logic [7:0] sup_clr;
  logic [7:0] trx_clr;
  logic [7:0] summary;
  logic overtemp_r;
  logic wd_fail;
  logic wd_reset;
  logic serial_fault;
  logic silence_hit;
  silence_state_t sil_state_r;
  silence_state_t sil_state_nxt;
  logic [SIL_CNT_W-1:0] sil_cnt_r;

  always_comb begin
    wd_fail = (wd_window_in && (sys_evt_in.wd_overflow || sys_evt_in.wd_early))
      || (wd_timeout_in && sys_evt_in.wd_overflow);
    wd_reset = (wd_window_in && (sys_evt_in.wd_overflow || sys_evt_in.wd_early))
      || (wd_timeout_in && sys_evt_in.wd_overflow && sys_flags[SYS_WATCHDOG]);
    serial_fault = (spi_frame_end_in && !spi_len_ok(spi_bit_count_in))
      || sys_evt_in.bad_wd_mode || sys_evt_in.bad_wd_period
      || sys_evt_in.bad_op_state || sys_evt_in.locked_write;
  end

  always_comb begin
    sys_set = 8'h00;
    sys_set[SYS_BATTERY] = sys_evt_in.battery_startup;
    sys_set[SYS_OVERTEMP] = cap_en_in.overtemp && !sleep_in
      && sys_evt_in.overtemp && !overtemp_r;
    sys_set[SYS_SERIAL] = cap_en_in.serial && !sleep_in && serial_fault;
    sys_set[SYS_WATCHDOG] = wd_fail;
  end

  always_comb begin
    sup_set = 8'h00;
    sup_set[SUP_OVER] = cap_en_in.sec_over && sup_evt_in.sec_over;
    sup_set[SUP_UNDER] = cap_en_in.sec_under && sup_evt_in.sec_under;
    // no threshold selection enters this term
    sup_set[SUP_MAIN_UNDER] = cap_en_in.main_under && sup_evt_in.main_under
      && main_reg_on_in && !sleep_in;
  end

  always_comb begin
    trx_set = 8'h00;
    trx_set[TRX_PN_ERR] = trx_evt_in.pn_frame_err;
    trx_set[TRX_SILENCE] = silence_hit;
  end

  // write-one-to-clear requests per group; writes to other addresses clear nothing
  always_comb begin
    sys_clr = clear_bits(reg_req_in, ADDR_SYSTEM);
    sup_clr = clear_bits(reg_req_in, ADDR_SUPPLY);
    trx_clr = clear_bits(reg_req_in, ADDR_TRX);
  end

  // sticky write-one-to-clear flag groups
  event_flag_bank #(.IMPL_MASK(SYS_MASK)) u_sys_flags (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .set_in(sys_set),
    .clear_in(sys_clr),
    .flags_out(sys_flags)
  );

  event_flag_bank #(.IMPL_MASK(SUP_MASK)) u_sup_flags (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .set_in(sup_set),
    .clear_in(sup_clr),
    .flags_out(sup_flags)
  );

  event_flag_bank #(.IMPL_MASK(TRX_MASK)) u_trx_flags (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .set_in(trx_set),
    .clear_in(trx_clr),
    .flags_out(trx_flags)
  );

  always_comb begin
    summary = 8'h00;
    summary[GLB_WAKE_PIN] = wake_pin_pending_in;
    summary[GLB_TRX] = (|trx_flags) || trx_other_pending_in;
    summary[GLB_SUPPLY] = |sup_flags;
    summary[GLB_SYSTEM] = |sys_flags;
  end

  // overtemperature edge detect
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overtemp_r <= 1'b0;
    end else begin
      overtemp_r <= sys_evt_in.overtemp;
    end
  end

  // bus silence detector
  always_comb begin
    sil_state_nxt = sil_state_r;
    silence_hit = 1'b0;
    unique case (sil_state_r)
      SIL_IDLE: begin
        if (cap_en_in.bus_silence && trx_evt_in.bus_active) begin
          sil_state_nxt = SIL_WATCH;
        end
      end
      SIL_WATCH: begin
        if (!cap_en_in.bus_silence) begin
          sil_state_nxt = SIL_IDLE;
        end else if (!trx_evt_in.bus_active && sil_cnt_r == SIL_LAST) begin
          silence_hit = 1'b1;
          sil_state_nxt = SIL_FIRED;
        end
      end
      SIL_FIRED: begin
        if (trx_evt_in.bus_active) begin
          sil_state_nxt = cap_en_in.bus_silence ? SIL_WATCH : SIL_IDLE;
        end
      end
      default: begin
        sil_state_nxt = SIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sil_state_r <= SIL_IDLE;
    end else begin
      sil_state_r <= sil_state_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sil_cnt_r <= SIL_CNT_RST;
    end else if (sil_state_r != SIL_WATCH || trx_evt_in.bus_active || silence_hit) begin
      sil_cnt_r <= SIL_CNT_RST;
    end else begin
      sil_cnt_r <= sil_cnt_r + 1'b1;
    end
  end

  // register read port
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= RDATA_RST;
    end else if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        ADDR_GLOBAL: reg_rdata_out <= summary;
        ADDR_SYSTEM: reg_rdata_out <= sys_flags;
        ADDR_SUPPLY: reg_rdata_out <= sup_flags;
        ADDR_TRX: reg_rdata_out <= trx_flags;
        default: reg_rdata_out <= RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxd_force_low_out <= 1'b0;
    end else begin
      rxd_force_low_out <= trx_offline_in && main_reg_on_in
        && (|summary[GLB_WAKE_PIN:GLB_SYSTEM]);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sys_reset_req_out <= 1'b0;
    end else begin
      sys_reset_req_out <= wd_reset;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      summary_out <= 8'h00;
    end else begin
      summary_out <= summary;
    end
  end

  a_summary_sys: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    ##1 (summary_out[GLB_SYSTEM] == (|$past(sys_flags))) && (summary_out[7:4] == 4'h0))
    else $error("system summary bit wrong");

  a_battery_set: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    sys_evt_in.battery_startup |=> sys_flags[SYS_BATTERY])
    else $error("battery startup flag not set");

  a_serial_len: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    spi_frame_end_in && !spi_len_ok(spi_bit_count_in) && cap_en_in.serial && !sleep_in
    |=> sys_flags[SYS_SERIAL])
    else $error("bad frame length not flagged");

  a_window_reset: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wd_window_in && sys_evt_in.wd_early |=> sys_reset_req_out && sys_flags[SYS_WATCHDOG])
    else $error("window failure gave no reset");

  a_timeout_first: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wd_timeout_in && !wd_window_in && sys_evt_in.wd_overflow && !sys_flags[SYS_WATCHDOG]
    |=> !sys_reset_req_out && sys_flags[SYS_WATCHDOG])
    else $error("first timeout overflow must only flag");

  a_timeout_reset: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    wd_timeout_in && !wd_window_in && sys_evt_in.wd_overflow && sys_flags[SYS_WATCHDOG]
    |=> sys_reset_req_out)
    else $error("repeat timeout overflow gave no reset");

  a_main_sleep: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    sleep_in && !sup_flags[SUP_MAIN_UNDER] |=> !sup_flags[SUP_MAIN_UNDER])
    else $error("main undervoltage captured in sleep");

  a_pn_err_set: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    trx_evt_in.pn_frame_err |=> trx_flags[TRX_PN_ERR] && (trx_flags & ~TRX_MASK) == 8'h00)
    else $error("frame error flag not set");

  a_flag_sticky: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    sys_flags[SYS_OVERTEMP] && !sys_clr[SYS_OVERTEMP]
    |=> sys_flags[SYS_OVERTEMP] [*1])
    else $error("overtemperature flag dropped");

  a_w1c_clear: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    sup_clr[SUP_OVER] && !sup_set[SUP_OVER]
    ##0 !sup_clr[SUP_UNDER] && sup_flags[SUP_UNDER]
    |=> !sup_flags[SUP_OVER] && sup_flags[SUP_UNDER])
    else $error("write one clear misbehaved");

  a_rxd_pending: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    trx_offline_in && main_reg_on_in && sys_flags != 8'h00 |=> rxd_force_low_out)
    else $error("receive pin not driven low");

  a_silence_fire: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    sil_state_r == SIL_WATCH && cap_en_in.bus_silence && !trx_evt_in.bus_active
    && sil_cnt_r == SIL_LAST |=> trx_flags[TRX_SILENCE] && sil_state_r == SIL_FIRED)
    else $error("bus silence not flagged");

endmodule : event_status_capture

// File: rtl/event_status_pkg.sv
package event_status_pkg;

  // register map of the serial register port
  localparam logic [6:0] ADDR_GLOBAL = 7'h60;
  localparam logic [6:0] ADDR_SYSTEM = 7'h61;
  localparam logic [6:0] ADDR_SUPPLY = 7'h62;
  localparam logic [6:0] ADDR_TRX = 7'h63;

  // global summary bit positions
  localparam int GLB_WAKE_PIN = 3;
  localparam int GLB_TRX = 2;
  localparam int GLB_SUPPLY = 1;
  localparam int GLB_SYSTEM = 0;

  // system flag positions
  localparam int SYS_BATTERY = 4;
  localparam int SYS_OVERTEMP = 2;
  localparam int SYS_SERIAL = 1;
  localparam int SYS_WATCHDOG = 0;

  // supply flag positions
  localparam int SUP_OVER = 2;
  localparam int SUP_UNDER = 1;
  localparam int SUP_MAIN_UNDER = 0;

  // transceiver flag positions
  localparam int TRX_PN_ERR = 5;
  localparam int TRX_SILENCE = 4;

  // implemented bits; reserved bits read zero
  localparam logic [7:0] SYS_MASK = 8'h17;
  localparam logic [7:0] SUP_MASK = 8'h07;
  localparam logic [7:0] TRX_MASK = 8'h30;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // legal serial frame lengths in clock counts
  localparam logic [5:0] SPI_LEN_A = 6'h10;
  localparam logic [5:0] SPI_LEN_B = 6'h18;
  localparam logic [5:0] SPI_LEN_C = 6'h20;

  // bus silence timeout
  localparam int CLK_MHZ = 200;
  localparam int SILENCE_TIME_US = 1000000;
  localparam int SILENCE_CYCLES = SILENCE_TIME_US * CLK_MHZ;
  localparam int SIL_CNT_W = 28;
  localparam logic [SIL_CNT_W-1:0] SIL_CNT_RST = 28'h0000000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic battery_startup;
    logic overtemp;
    logic bad_wd_mode;
    logic bad_wd_period;
    logic bad_op_state;
    logic locked_write;
    logic wd_overflow;
    logic wd_early;
  } sys_evt_t;

  typedef struct packed {
    logic sec_over;
    logic sec_under;
    logic main_under;
  } sup_evt_t;

  typedef struct packed {
    logic pn_frame_err;
    logic bus_active;
  } trx_evt_t;

  typedef struct packed {
    logic overtemp;
    logic serial;
    logic sec_over;
    logic sec_under;
    logic main_under;
    logic bus_silence;
  } cap_en_t;

  typedef enum logic [2:0] {
    SIL_IDLE = 3'b001,
    SIL_WATCH = 3'b010,
    SIL_FIRED = 3'b100
  } silence_state_t;

  // bits that a write of ones asks to clear in the register at addr
  function automatic logic [7:0] clear_bits(input reg_req_t req, input logic [6:0] addr);
    clear_bits = (req.wr && req.addr == addr) ? req.wdata : 8'h00;
  endfunction : clear_bits

  function automatic logic spi_len_ok(input logic [5:0] len);
    spi_len_ok = (len == SPI_LEN_A) || (len == SPI_LEN_B) || (len == SPI_LEN_C);
  endfunction : spi_len_ok

endpackage : event_status_pkg

// File: rtl/event_flag_bank.sv
module event_flag_bank
  import event_status_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  input wire logic sys_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [7:0] set_in, // capture pulses
  input wire logic [7:0] clear_in, // write-one-to-clear bits
  output logic [7:0] flags_out // sticky flags
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // a set in the cycle of its clear wins, so no event is lost
  always_comb begin
    flags_nxt = ((flags_r & ~clear_in) | set_in) & IMPL_MASK;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

endmodule : event_flag_bank

// File: tb/host_model.sv
module host_model
  import event_status_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  output reg_req_t reg_req_out, // register request to the device
  input wire logic [7:0] reg_rdata_in // read data from the device
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req_out = '0;

  // a released request shows the inverse address and data
  task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [6:0] addr, output logic [7:0] data);
    @(posedge sys_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge sys_clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    #1;
    data = reg_rdata_in;
  endtask : reg_read
endmodule : host_model

// File: tb/tb_top.sv
module tb_top
  import event_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SIL = 20;
  typedef struct packed {
    logic [5:0] en;
    logic slp;
    logic mon;
    logic [11:0] ev;
    logic [6:0] addr;
    logic [7:0] exp;
  } case_t;

  logic sys_clk_in, reset_n_in, sleep, wd_window, wd_timeout, frame_end;
  logic offline, main_on, wake_pend, trx_pend, rxd_low, rst_req;
  logic [5:0] bit_count;
  logic [7:0] rdata, summary, rv;
  reg_req_t reg_req;
  sys_evt_t sys_evt;
  sup_evt_t sup_evt;
  trx_evt_t trx_evt;
  cap_en_t cap_en;
  case_t tbl [15];
  logic [5:0] lens [8];
  int n_errors, n_checks, n;

  event_status_capture #(.SILENCE_CYC(SIL)) event_status_capture_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req),
    .reg_rdata_out(rdata), .sys_evt_in(sys_evt), .sup_evt_in(sup_evt), .trx_evt_in(trx_evt),
    .cap_en_in(cap_en), .sleep_in(sleep), .wd_window_in(wd_window), .wd_timeout_in(wd_timeout),
    .spi_frame_end_in(frame_end), .spi_bit_count_in(bit_count), .trx_offline_in(offline),
    .main_reg_on_in(main_on), .wake_pin_pending_in(wake_pend),
    .trx_other_pending_in(trx_pend), .rxd_force_low_out(rxd_low),
    .sys_reset_req_out(rst_req), .summary_out(summary));

  host_model host_model_i (.sys_clk_in(sys_clk_in), .reg_req_out(reg_req),
    .reg_rdata_in(rdata));

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_model_i.reg_read(addr, d);
    check(d, exp);
  endtask : rd_chk

  task automatic pulse(input logic [11:0] v);
    @(posedge sys_clk_in);
    {sys_evt, sup_evt, trx_evt.pn_frame_err} <= v;
    @(posedge sys_clk_in);
    {sys_evt, sup_evt, trx_evt.pn_frame_err} <= 12'h000;
    #1;
  endtask : pulse

  task automatic setup(input logic [5:0] en, input logic slp, input logic mon);
    @(posedge sys_clk_in);
    cap_en <= cap_en_t'(en);
    sleep <= slp;
    main_on <= mon;
  endtask : setup

  function automatic logic [7:0] glb(input logic [6:0] a, input logic [7:0] e);
    glb = (e == 8'h00) ? 8'h00 : (8'h01 << (a - ADDR_SYSTEM));
  endfunction : glb

  initial begin
    #100us;
    n_errors++;
    test_done();
  end

  initial begin
    reset_n_in = 1'b0;
    {sys_evt, sup_evt, trx_evt, cap_en} = '0;
    {sleep, wd_window, wd_timeout, frame_end, offline, wake_pend, trx_pend} = '0;
    main_on = 1'b1;
    bit_count = 6'h10;
    n_errors = 0;
    n_checks = 0;
    tbl = '{'{6'h00, 0, 1, 12'h400, ADDR_SYSTEM, 8'h00}, '{6'h20, 1, 1, 12'h400, ADDR_SYSTEM, 8'h00},
      '{6'h20, 0, 1, 12'h400, ADDR_SYSTEM, 8'h04}, '{6'h10, 0, 1, 12'h200, ADDR_SYSTEM, 8'h02},
      '{6'h10, 0, 1, 12'h100, ADDR_SYSTEM, 8'h02}, '{6'h10, 0, 1, 12'h080, ADDR_SYSTEM, 8'h02},
      '{6'h10, 0, 1, 12'h040, ADDR_SYSTEM, 8'h02}, '{6'h10, 1, 1, 12'h040, ADDR_SYSTEM, 8'h00},
      '{6'h00, 0, 1, 12'h200, ADDR_SYSTEM, 8'h00}, '{6'h08, 0, 1, 12'h008, ADDR_SUPPLY, 8'h04},
      '{6'h00, 0, 1, 12'h008, ADDR_SUPPLY, 8'h00}, '{6'h04, 0, 1, 12'h004, ADDR_SUPPLY, 8'h02},
      '{6'h02, 0, 1, 12'h002, ADDR_SUPPLY, 8'h01}, '{6'h02, 1, 1, 12'h002, ADDR_SUPPLY, 8'h00},
      '{6'h00, 0, 1, 12'h001, ADDR_TRX, 8'h20}};
    lens = '{6'h10, 6'h18, 6'h20, 6'h0f, 6'h11, 6'h19, 6'h21, 6'h08};
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    for (int a = 'h60; a < 'h66; a++) rd_chk(7'(a), 8'h00);
    pulse(12'h800);
    rd_chk(ADDR_SYSTEM, 8'h10);
    @(posedge sys_clk_in);
    wake_pend <= 1'b1;
    trx_pend <= 1'b1;
    rd_chk(ADDR_GLOBAL, 8'h0d);
    check(summary, 8'h0d);
    @(posedge sys_clk_in);
    {wake_pend, trx_pend} <= 2'b00;
    offline <= 1'b1;
    host_model_i.reg_write(ADDR_GLOBAL, 8'hff);
    host_model_i.reg_write(ADDR_SYSTEM, 8'h00);
    rd_chk(ADDR_SYSTEM, 8'h10);
    check({7'h00, rxd_low}, 8'h01);
    host_model_i.reg_write(ADDR_SYSTEM, 8'h10);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check(summary, 8'h00);
    check({7'h00, rxd_low}, 8'h00);
    offline <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      setup(tbl[i].en, tbl[i].slp, tbl[i].mon);
      pulse(tbl[i].ev);
      rd_chk(tbl[i].addr, tbl[i].exp);
      rd_chk(ADDR_GLOBAL, glb(tbl[i].addr, tbl[i].exp));
      host_model_i.reg_write(tbl[i].addr, 8'hff);
      rd_chk(tbl[i].addr, 8'h00);
    end
    setup(6'h0c, 0, 1);
    pulse(12'h00c);
    host_model_i.reg_write(ADDR_SUPPLY, 8'h04);
    rd_chk(ADDR_SUPPLY, 8'h02);
    host_model_i.reg_write(ADDR_SUPPLY, 8'h06);
    rd_chk(ADDR_SUPPLY, 8'h00);
    setup(6'h02, 0, 0);
    pulse(12'h002);
    rd_chk(ADDR_SUPPLY, 8'h00);
    for (int i = 0; i < 9; i++) begin
      setup(6'h10, i == 8, 1);
      @(posedge sys_clk_in);
      frame_end <= 1'b1;
      bit_count <= lens[(i < 8) ? i : 7];
      @(posedge sys_clk_in);
      frame_end <= 1'b0;
      rd_chk(ADDR_SYSTEM, (i >= 3 && i < 8) ? 8'h02 : 8'h00);
      host_model_i.reg_write(ADDR_SYSTEM, 8'hff);
    end
    setup(6'h00, 0, 1);
    wd_timeout <= 1'b1;
    pulse(12'h020);
    check({7'h00, rst_req}, 8'h00);
    rd_chk(ADDR_SYSTEM, 8'h01);
    pulse(12'h020);
    check({7'h00, rst_req}, 8'h01);
    host_model_i.reg_write(ADDR_SYSTEM, 8'hff);
    {wd_timeout, wd_window} <= 2'b01;
    pulse(12'h010);
    check({7'h00, rst_req}, 8'h01);
    rd_chk(ADDR_SYSTEM, 8'h01);
    host_model_i.reg_write(ADDR_SYSTEM, 8'hff);
    pulse(12'h020);
    check({7'h00, rst_req}, 8'h01);
    host_model_i.reg_write(ADDR_SYSTEM, 8'hff);
    setup(6'h01, 0, 1);
    wd_window <= 1'b0;
    repeat (30) @(posedge sys_clk_in);
    rd_chk(ADDR_TRX, 8'h00);
    @(posedge sys_clk_in);
    trx_evt.bus_active <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    trx_evt.bus_active <= 1'b0;
    repeat (SIL - 8) @(posedge sys_clk_in);
    rd_chk(ADDR_TRX, 8'h00);
    n = 0;
    while (summary[GLB_TRX] !== 1'b1 && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    check({7'h00, summary[GLB_TRX]}, 8'h01);
    rd_chk(ADDR_TRX, 8'h10);
    test_done();
  end
endmodule : tb_top
